/* rtl/pmc_counters.v */
/*
 four-channel performance measurement counter with axi4-lite slave.
 assumes event inputs come from cpu logic on i_clk (no synchronisers
 needed); i_clk is the cpu clock and stops in sleep.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`include "pmc_map.vh"
module pmc_counters #(
   parameter NUM_CH = 4,
   parameter CNT_W = 32,
   parameter HAS_DSP = 1,
   parameter HAS_MMU = 1,
   parameter HAS_XY = 1,
   parameter HAS_URAM = 1
) (
   input wire i_clk,
   input wire i_resetn,
   // axi4-lite slave
   input wire [7:0] i_awaddr,
   input wire i_awvalid,
   output wire o_awready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   input wire i_wvalid,
   output wire o_wready,
   output reg [1:0] o_bresp,
   output reg o_bvalid,
   input wire i_bready,
   input wire [7:0] i_araddr,
   input wire i_arvalid,
   output wire o_arready,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   output reg o_rvalid,
   input wire i_rready,
   // cpu status and event pulses
   input wire i_prog_start,
   input wire i_break_hit,
   input wire i_cond1_match,
   input wire i_cond2_match,
   input wire i_exec_state,
   input wire i_branch_event,
   input wire i_instr_done,
   input wire i_dsp_instr,
   input wire i_exception_event,
   input wire i_interrupt,
   input wire i_instruction_cache_miss_event,
   input wire i_data_cache_miss_event,
   input wire i_ifetch_stall,
   input wire i_dacc_stall,
   input wire i_data_tlb_miss_cycles,
   input wire i_itlb_miss_cycle,
   input wire i_xy_stall,
   input wire i_uram_stall,
   input wire i_acc_cycle,
   input wire i_acc_start,
   input wire i_acc_cacheable_area,
   // status out
   output wire o_measuring,
   output wire o_break_suppress,
   output wire [NUM_CH-1:0] o_overflow
);

////////////////////////////////////////////////////////////////////////////////
// event class decode: returns increment amount for one channel

// increment for the selected class: 0, 1, or 2 for a branch
function [1:0] ev_incr;
   input [5:0] sel;
   input [19:0] ev;
   begin
      ev_incr = 2'h0;
      case (sel)
         `PMC_EV_TIME: ev_incr = 2'h1;
         `PMC_EV_STATE: ev_incr = {1'b0, ev[0]};
         `PMC_EV_BRANCH: ev_incr = ev[1] ? 2'h2 : 2'h0;
         `PMC_EV_INSTR: ev_incr = {1'b0, ev[2]};
         `PMC_EV_DSP_INSTR: ev_incr = {1'b0, ev[3]};
         `PMC_EV_EXCEPTION: ev_incr = {1'b0, ev[4]};
         `PMC_EV_ICMISS: ev_incr = {1'b0, ev[5]};
         `PMC_EV_DCMISS: ev_incr = {1'b0, ev[6]};
         `PMC_EV_IFSTALL: ev_incr = {1'b0, ev[7]};
         `PMC_EV_DASTALL: ev_incr = {1'b0, ev[8]};
         `PMC_EV_DTLB: ev_incr = {1'b0, ev[9]};
         `PMC_EV_ITLB: ev_incr = {1'b0, ev[10]};
         `PMC_EV_XYSTALL: ev_incr = {1'b0, ev[11]};
         `PMC_EV_USTALL: ev_incr = {1'b0, ev[12]};
         `PMC_EV_NC_CYC: ev_incr = {1'b0, ev[13]};
         `PMC_EV_C_CYC: ev_incr = {1'b0, ev[14]};
         `PMC_EV_NC_CNT: ev_incr = {1'b0, ev[15]};
         `PMC_EV_C_CNT: ev_incr = {1'b0, ev[16]};
         `PMC_EV_INTR: ev_incr = {1'b0, ev[17]};
         default: ev_incr = 2'h0; // disabled or unknown: no count
      endcase
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// event vector, gated by presence of optional units

wire [19:0] ev_vec; // one bit per event class other than time, access lines split by area, top two bits zero
// area split: cacheable-area attribute only, tlb cacheable bit ignored
wire acc_nc; // non-cacheable area access cycle
wire acc_c; // cacheable area access cycle
assign acc_nc = i_acc_cycle & ~i_acc_cacheable_area;
assign acc_c = i_acc_cycle & i_acc_cacheable_area;
assign ev_vec = {2'b00,
   i_interrupt,
   i_acc_start & i_acc_cacheable_area,
   i_acc_start & ~i_acc_cacheable_area,
   acc_c,
   acc_nc,
   i_uram_stall & (HAS_URAM != 0),
   i_xy_stall & (HAS_XY != 0),
   i_itlb_miss_cycle & (HAS_MMU != 0),
   i_data_tlb_miss_cycles & (HAS_MMU != 0),
   i_dacc_stall,
   i_ifetch_stall,
   i_data_cache_miss_event,
   i_instruction_cache_miss_event,
   i_exception_event,
   i_dsp_instr & (HAS_DSP != 0),
   i_instr_done,
   i_branch_event,
   i_exec_state};

////////////////////////////////////////////////////////////////////////////////
// measurement window state machine

localparam ST_IDLE = 3'b001; // waiting for start
localparam ST_RUN = 3'b010; // counting
localparam ST_DONE = 3'b100; // window closed

reg [2:0] state_reg; // window state
reg [2:0] state_next;
reg [1:0] mode_reg; // window mode, from control register
reg init_pulse; // one-cycle initialize request
wire start_ev; // start event for current mode
wire stop_ev; // stop event for current mode

assign start_ev = (mode_reg == `PMC_MODE_FWD) ? i_cond1_match :
   (mode_reg == `PMC_MODE_REV) ? i_cond2_match :
   i_prog_start;
assign stop_ev = (mode_reg == `PMC_MODE_FWD) ? i_cond2_match :
   (mode_reg == `PMC_MODE_REV) ? i_cond1_match :
   i_break_hit;

// next-state logic
always @* begin
   state_next = state_reg;
   case (state_reg)
      ST_IDLE: begin
         if (start_ev) begin
            state_next = ST_RUN;
         end
      end
      ST_RUN: begin
         if (stop_ev) begin
            state_next = ST_DONE;
         end
      end
      ST_DONE: begin
         if (mode_reg == `PMC_MODE_NORMAL && i_prog_start) begin
            state_next = ST_RUN; // next run resumes accumulation
         end
      end
      default: state_next = ST_IDLE;
   endcase
   if (init_pulse) begin
      state_next = ST_IDLE;
   end
end

// state register
always @(posedge i_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      state_reg <= ST_IDLE;
   end else begin
      state_reg <= state_next;
   end
end

assign o_measuring = (state_reg == ST_RUN);
// window matches are consumed here, never passed on as a break
assign o_break_suppress = (mode_reg != `PMC_MODE_NORMAL);

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write path

reg aw_got_reg; // address taken
reg w_got_reg; // data taken
reg [7:0] awaddr_reg;
reg [31:0] wdata_reg;
reg wstrb0_reg; // byte lane 0 enable, taken with the data
reg [5:0] chcfg_reg [0:NUM_CH-1]; // event class per channel
wire wr_fire; // both halves present, response free

assign o_awready = ~aw_got_reg & ~o_bvalid;
assign o_wready = ~w_got_reg & ~o_bvalid;
assign wr_fire = aw_got_reg & w_got_reg & ~o_bvalid;

// capture address and data independently
always @(posedge i_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
   end else begin
      if (i_awvalid && o_awready) begin
         aw_got_reg <= 1'b1;
         awaddr_reg <= i_awaddr;
      end else if (wr_fire) begin
         aw_got_reg <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
         w_got_reg <= 1'b1;
         wdata_reg <= i_wdata;
         wstrb0_reg <= i_wstrb[0];
      end else if (wr_fire) begin
         w_got_reg <= 1'b0;
      end
   end
end

// register writes and write response
integer k;
always @(posedge i_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      o_bvalid <= 1'b0;
      o_bresp <= `PMC_RESP_OKAY;
      mode_reg <= `PMC_MODE_NORMAL;
      init_pulse <= 1'b0;
      for (k = 0; k < NUM_CH; k = k + 1) begin
         chcfg_reg[k] <= `PMC_CHCFG_RST;
      end
   end else begin
      init_pulse <= 1'b0;
      if (o_bvalid && i_bready) begin
         o_bvalid <= 1'b0;
      end
      if (wr_fire) begin
         o_bvalid <= 1'b1;
         o_bresp <= `PMC_RESP_OKAY;
         if ({awaddr_reg[7:2], 2'b00} == `PMC_CTRL_OFS) begin
            if (wstrb0_reg) begin
               mode_reg <= wdata_reg[`PMC_CTRL_MODE_LSB +: 2];
               init_pulse <= wdata_reg[`PMC_CTRL_INIT_BIT];
            end
         end else if ({awaddr_reg[7:4], 4'h0} == `PMC_CHCFG_OFS) begin
            if (wstrb0_reg) begin
               chcfg_reg[awaddr_reg[3:2]] <= wdata_reg[5:0];
            end
         end else if ({awaddr_reg[7:4], 4'h0} == `PMC_CNT_OFS) begin
            o_bresp <= `PMC_RESP_OKAY; // counters read-only, write ignored
         end else if ({awaddr_reg[7:2], 2'b00} == `PMC_STAT_OFS) begin
            o_bresp <= `PMC_RESP_OKAY; // status read-only
         end else begin
            o_bresp <= `PMC_RESP_SLVERR; // unmapped
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// counting channels

reg [CNT_W-1:0] cnt_reg [0:NUM_CH-1]; // channel results
reg [NUM_CH-1:0] ovf_reg; // sticky overflow per channel

genvar g;
generate
   for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
      wire [1:0] inc; // increment this cycle
      wire [CNT_W:0] sum; // count with carry
      assign inc = o_measuring ? ev_incr(chcfg_reg[g], ev_vec) : 2'h0;
      assign sum = {1'b0, cnt_reg[g]} + {{(CNT_W-1){1'b0}}, inc};
      // counter runs on cpu clock, frozen when it stops
      always @(posedge i_clk or negedge i_resetn) begin
         if (!i_resetn) begin
            cnt_reg[g] <= {CNT_W{1'b0}};
            ovf_reg[g] <= 1'b0;
         end else if (init_pulse) begin
            cnt_reg[g] <= {CNT_W{1'b0}};
            ovf_reg[g] <= 1'b0;
         end else begin
            cnt_reg[g] <= sum[CNT_W-1:0];
            if (sum[CNT_W]) begin
               ovf_reg[g] <= 1'b1;
            end
         end
      end
   end
endgenerate

assign o_overflow = ovf_reg;

////////////////////////////////////////////////////////////////////////////////
// axi4-lite read path

assign o_arready = ~o_rvalid;

// read decode and data return
always @(posedge i_clk or negedge i_resetn) begin
   if (!i_resetn) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `PMC_RESP_OKAY;
   end else begin
      if (o_rvalid && i_rready) begin
         o_rvalid <= 1'b0;
      end
      if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         o_rresp <= `PMC_RESP_OKAY;
         o_rdata <= 32'h0000_0000;
         if ({i_araddr[7:2], 2'b00} == `PMC_CTRL_OFS) begin
            o_rdata[`PMC_CTRL_MODE_LSB +: 2] <= mode_reg;
         end else if ({i_araddr[7:2], 2'b00} == `PMC_STAT_OFS) begin
            o_rdata[`PMC_STAT_OVF_LSB +: NUM_CH] <= ovf_reg;
            o_rdata[`PMC_STAT_RUN_BIT] <= o_measuring;
         end else if ({i_araddr[7:4], 4'h0} == `PMC_CHCFG_OFS) begin
            o_rdata[5:0] <= chcfg_reg[i_araddr[3:2]];
         end else if ({i_araddr[7:4], 4'h0} == `PMC_CNT_OFS) begin
            o_rdata[CNT_W-1:0] <= cnt_reg[i_araddr[3:2]];
         end else begin
            o_rresp <= `PMC_RESP_SLVERR; // unmapped
         end
      end
   end
end

endmodule // pmc_counters

/* rtl/pmc_map.vh */
/*
 performance measurement counter constants: register offsets, field
 positions, reset values and event class codes.
 assumes inclusion by bare name from the counter block.
*/
`ifndef PMC_MAP_VH
`define PMC_MAP_VH
// register byte offsets
`define PMC_CTRL_OFS 8'h00
`define PMC_STAT_OFS 8'h04
`define PMC_CHCFG_OFS 8'h10
`define PMC_CNT_OFS 8'h20
// control fields
`define PMC_CTRL_MODE_LSB 0
`define PMC_CTRL_INIT_BIT 4
`define PMC_CTRL_RST 32'h0000_0000
// status fields
`define PMC_STAT_OVF_LSB 0
`define PMC_STAT_RUN_BIT 8
// channel config reset
`define PMC_CHCFG_RST 6'h00
// window modes
`define PMC_MODE_NORMAL 2'h0
`define PMC_MODE_FWD 2'h1
`define PMC_MODE_REV 2'h2
// event classes
`define PMC_EV_DISABLED 6'h00
`define PMC_EV_TIME 6'h01
`define PMC_EV_STATE 6'h02
`define PMC_EV_BRANCH 6'h03
`define PMC_EV_INSTR 6'h04
`define PMC_EV_DSP_INSTR 6'h05
`define PMC_EV_EXCEPTION 6'h06
`define PMC_EV_ICMISS 6'h07
`define PMC_EV_DCMISS 6'h08
`define PMC_EV_IFSTALL 6'h09
`define PMC_EV_DASTALL 6'h0a
`define PMC_EV_DTLB 6'h0b
`define PMC_EV_ITLB 6'h0c
`define PMC_EV_XYSTALL 6'h0d
`define PMC_EV_USTALL 6'h0e
`define PMC_EV_NC_CYC 6'h0f
`define PMC_EV_C_CYC 6'h10
`define PMC_EV_NC_CNT 6'h11
`define PMC_EV_C_CNT 6'h12
`define PMC_EV_INTR 6'h13
// axi responses
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2
`endif

/* tb/pmc_counters_checker.sv */
/* checker for the counter block: bus and window timing.
   assumes a bind onto pmc_counters, one clock domain. */
module pmc_checker (
   input wire i_clk,
   input wire i_resetn,
   input wire o_awready,
   input wire [1:0] o_bresp,
   input wire o_bvalid,
   input wire i_bready,
   input wire i_arvalid,
   input wire o_arready,
   input wire [31:0] o_rdata,
   input wire o_rvalid,
   input wire i_rready,
   input wire i_prog_start,
   input wire i_break_hit,
   input wire i_cond1_match,
   input wire i_cond2_match,
   input wire o_measuring,
   input wire o_break_suppress
);
////////////////////////////////////////////////////////////////////////////////
   // one clock, reset disables all
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped");
   a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   a_ar_refused: assert property (o_rvalid |-> !o_arready)
      else $error("read taken while busy");
   a_aw_refused: assert property (o_bvalid |-> !o_awready)
      else $error("write taken while busy");
   a_norm_start: assert property (!o_break_suppress && !o_measuring && i_prog_start
      && !i_break_hit && !o_bvalid |=> o_measuring) else $error("window not opened");
   a_norm_stop: assert property (!o_break_suppress && o_measuring && i_break_hit
      && !o_bvalid |=> !o_measuring) else $error("window not closed");
   a_brk_noprog: assert property (o_break_suppress && !o_measuring && i_prog_start
      && !i_cond1_match && !i_cond2_match && !o_bvalid
      |=> !o_measuring ##1 (!o_measuring || $past(i_cond1_match || i_cond2_match)))
      else $error("window opened early");
endmodule // pmc_checker

bind pmc_counters pmc_checker u_pmc_checker (.i_clk(i_clk), .i_resetn(i_resetn),
   .o_awready(o_awready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
   .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
   .o_rvalid(o_rvalid), .i_rready(i_rready), .i_prog_start(i_prog_start),
   .i_break_hit(i_break_hit), .i_cond1_match(i_cond1_match),
   .i_cond2_match(i_cond2_match), .o_measuring(o_measuring),
   .o_break_suppress(o_break_suppress));

/* tb/pmc_host.sv */
/* debug host model: axi4-lite master with write and read tasks.
   assumes tasks are called from the bench, one at a time. */
module pmc_host (
   input wire i_clk,
   output logic [7:0] o_awaddr,
   output logic o_awvalid,
   output logic [31:0] o_wdata,
   output logic o_wvalid,
   output logic o_bready,
   output logic [7:0] o_araddr,
   output logic o_arvalid,
   output logic o_rready,
   input wire i_awready,
   input wire i_wready,
   input wire [1:0] i_bresp,
   input wire i_bvalid,
   input wire i_arready,
   input wire [31:0] i_rdata,
   input wire [1:0] i_rresp,
   input wire i_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   int tmo = 0; // waits that ran out
   // idle bus at time zero
   initial begin
      {o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready} = '0;
      {o_araddr, o_arvalid, o_rready} = '0;
   end
////////////////////////////////////////////////////////////////////////////////
   // write: both halves offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      bit aw, w, b;
      n = 0;
      {aw, w, b} = 3'b111;
      r = 2'h3;
      @(posedge i_clk);
      o_awaddr <= a;
      o_wdata <= d;
      {o_awvalid, o_wvalid, o_bready} <= 3'b111;
      while (b && n < 64) begin
         @(posedge i_clk);
         n++;
         if (aw && i_awready) begin
            aw = 0;
            o_awvalid <= 1'b0;
         end
         if (w && i_wready) begin
            w = 0;
            o_wvalid <= 1'b0;
         end
         if (!aw && !w && i_bvalid) begin
            b = 0;
            r = i_bresp;
            o_bready <= 1'b0;
         end
      end
      if (b) tmo++;
   endtask
   // read: address held until taken, data taken with rvalid
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      bit ar, rv;
      n = 0;
      {ar, rv} = 2'b11;
      {d, r} = '1;
      @(posedge i_clk);
      o_araddr <= a;
      {o_arvalid, o_rready} <= 2'b11;
      while (rv && n < 64) begin
         @(posedge i_clk);
         n++;
         if (ar && i_arready) begin
            ar = 0;
            o_arvalid <= 1'b0;
         end else if (!ar && i_rvalid) begin
            rv = 0;
            {d, r} = {i_rdata, i_rresp};
            o_rready <= 1'b0;
         end
      end
      if (rv) tmo++;
   endtask
endmodule // pmc_host

/* tb/tb_top.sv */
/* self-checking bench for the counter block.
   assumes the host model drives the bus and the bench the cpu events. */
`include "pmc_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [20:0] ev = '0; // cpu status and event lines
   int bad_count = 0;
   int cmp_count = 0;
   wire [7:0] aa, ra;
   wire [31:0] wd, rdat;
   wire [1:0] br, rr;
   wire [3:0] ovf;
   wire av, ay, wv, wy, bv, by, qv, qy, rv, ry, meas, sup;
   // event line carried by each class code
   localparam int EVI[20] = '{0, 0, 4, 5, 6, 7, 8, 10, 11, 12, 13, 14, 15, 16, 17, 18, 18,
      19, 19, 9};
   always #2 i_clk = ~i_clk;
   pmc_counters u_pmc_counters (.i_clk(i_clk), .i_resetn(i_resetn), .i_awaddr(aa),
      .i_awvalid(av), .o_awready(ay), .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv),
      .o_wready(wy), .o_bresp(br), .o_bvalid(bv), .i_bready(by), .i_araddr(ra),
      .i_arvalid(qv), .o_arready(qy), .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv),
      .i_rready(ry), .i_prog_start(ev[0]), .i_break_hit(ev[1]), .i_cond1_match(ev[2]),
      .i_cond2_match(ev[3]), .i_exec_state(ev[4]), .i_branch_event(ev[5]),
      .i_instr_done(ev[6]), .i_dsp_instr(ev[7]), .i_exception_event(ev[8]),
      .i_interrupt(ev[9]), .i_instruction_cache_miss_event(ev[10]),
      .i_data_cache_miss_event(ev[11]), .i_ifetch_stall(ev[12]), .i_dacc_stall(ev[13]),
      .i_data_tlb_miss_cycles(ev[14]), .i_itlb_miss_cycle(ev[15]), .i_xy_stall(ev[16]),
      .i_uram_stall(ev[17]), .i_acc_cycle(ev[18]), .i_acc_start(ev[19]),
      .i_acc_cacheable_area(ev[20]), .o_measuring(meas), .o_break_suppress(sup),
      .o_overflow(ovf));
   pmc_host u_pmc_host (.i_clk(i_clk), .o_awaddr(aa), .o_awvalid(av), .o_wdata(wd),
      .o_wvalid(wv), .o_bready(by), .o_araddr(ra), .o_arvalid(qv), .o_rready(ry),
      .i_awready(ay), .i_wready(wy), .i_bresp(br), .i_bvalid(bv), .i_arready(qy),
      .i_rdata(rdat), .i_rresp(rr), .i_rvalid(rv));
////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      u_pmc_host.rd(a, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, er});
   endtask
   task automatic wrc(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      u_pmc_host.wr(a, d, r);
      chk({30'h0, r}, {30'h0, `PMC_RESP_OKAY});
   endtask
   task automatic step(input logic [20:0] v);
      @(posedge i_clk);
      ev <= v;
   endtask
   task automatic do_reset;
      i_resetn <= 1'b0;
      repeat (6) @(posedge i_clk);
      i_resetn <= 1'b1;
   endtask
////////////////////////////////////////////////////////////////////////////////
   // every register reads zero, unmapped read refused
   task automatic t_reset;
      rdc(`PMC_CTRL_OFS, 0, `PMC_RESP_OKAY);
      rdc(`PMC_STAT_OFS, 0, `PMC_RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         rdc(`PMC_CHCFG_OFS + 4 * i, 0, `PMC_RESP_OKAY);
         rdc(`PMC_CNT_OFS + 4 * i, 0, `PMC_RESP_OKAY);
      end
      rdc(8'h40, 0, `PMC_RESP_SLVERR);
      $display("test reset done");
   endtask
   // each class in a normal window, with wrong-area cycles
   task automatic t_classes;
      logic [20:0] v;
      int e;
      for (int c = 1; c < 20; c++) begin
         wrc(`PMC_CTRL_OFS, 32'h10);
         rdc(`PMC_CNT_OFS, 0, `PMC_RESP_OKAY);
         wrc(`PMC_CHCFG_OFS, c);
         wrc(`PMC_CHCFG_OFS + 4, 1);
         wrc(`PMC_CHCFG_OFS + 12, c);
         chk({31'h0, sup}, 0);
         step(21'h1);
         for (int i = 0; i < 5; i++) begin
            v = '0;
            if (c > 1) v[EVI[c]] = 1'b1;
            v[20] = ((i < 3) == (c == 16 || c == 18));
            step(v);
         end
         chk({31'h0, meas}, 1);
         step(21'h2);
         step(21'h0);
         // time counts the stop cycle too: six cycles in the window
         e = (c >= 15 && c <= 18) ? 3 : (c == 3) ? 10 : (c == 1) ? 6 : 5;
         rdc(`PMC_CNT_OFS, e, `PMC_RESP_OKAY);
         rdc(`PMC_CNT_OFS + 4, 6, `PMC_RESP_OKAY);
         rdc(`PMC_CNT_OFS + 8, 0, `PMC_RESP_OKAY);
         rdc(`PMC_CNT_OFS + 12, e, `PMC_RESP_OKAY);
         chk({31'h0, meas}, 0);
      end
      rdc(`PMC_STAT_OFS, 0, `PMC_RESP_OKAY);
      chk({28'h0, ovf}, 0);
      $display("test classes done");
   endtask
   // both break modes: start, stop, and a start match after stop
   task automatic t_break;
      logic [20:0] go, halt;
      for (int m = 1; m < 3; m++) begin
         go = (m == 1) ? 21'h4 : 21'h8;
         halt = (m == 1) ? 21'h8 : 21'h4;
         wrc(`PMC_CTRL_OFS, 32'h10 | m);
         wrc(`PMC_CHCFG_OFS, 1);
         rdc(`PMC_CTRL_OFS, m, `PMC_RESP_OKAY);
         chk({31'h0, sup}, 1);
         step(halt | 21'h1);
         step(21'h0);
         step(go);
         repeat (3) step(21'h0);
         chk({31'h0, meas}, 1);
         rdc(`PMC_STAT_OFS, 32'h100, `PMC_RESP_OKAY);
         step(halt);
         step(go);
         step(21'h0);
         // seven open cycles, stop cycle included
         rdc(`PMC_CNT_OFS, 7, `PMC_RESP_OKAY);
         chk({31'h0, meas}, 0);
      end
      $display("test break modes done");
   endtask
   task automatic test_done;
      bad_count = bad_count + u_pmc_host.tmo;
      $display("compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      repeat (90000) @(posedge i_clk);
      bad_count++;
      test_done;
   end
   initial begin
      do_reset;
      t_reset;
      t_classes;
      t_break;
      do_reset;
      t_reset;
      test_done;
   end
endmodule // tb_top
